/* design/mip_multi_io_program.sv */
`timescale 1ns/1ns
module mip_multi_io_program
  import mip_pkg::*;
#(
  parameter int unsigned PAGE_PROG_CYCLES = MIP_PAGE_PROG_CYC,
  parameter int unsigned BYTE_PROG_CYCLES = MIP_BYTE_PROG_CYC
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        arst_n,
  // Serial bus pins
  input  wire logic        sck,
  input  wire logic        cs_n,
  input  wire logic [3:0]  io_in,
  // Neighbouring command and protection logic
  input  wire logic        latch_set,
  input  wire logic        addr_protected,
  output logic      [23:0] cmd_addr,
  // Status bits
  output logic             busy,
  output logic             write_enable_latch,
  output logic             program_erase_error_flag,
  // Array write and verify port
  output logic             arr_we,
  output logic      [23:0] arr_addr,
  output logic      [7:0]  arr_wdata,
  input  wire logic [7:0]  arr_rdata
);

  localparam int TW = $clog2(PAGE_PROG_CYCLES + 1);

  if (BYTE_PROG_CYCLES < 1 || BYTE_PROG_CYCLES > PAGE_PROG_CYCLES) begin
    $error("byte program cycles must lie between 1 and page cycles");
  end

  typedef struct packed {
    logic [5:0]            s1;
    logic [5:0]            s2;
    logic [1:0]            prev;
    mip_st_type            st;
    logic [4:0]            bitc;
    logic [30:0]           sh;
    logic [1:0]            mode;
    logic [23:0]           addr;
    logic [7:0]            bsh;
    logic [1:0]            nib;
    logic [7:0]            ofs;
    logic [8:0]            cnt;
    logic [255:0]          vld;
    logic [255:0][7:0]     pbuf;
    logic [8:0]            idx;
    logic [1:0]            step;
    logic [TW-1:0]         tmr;
    logic                  latch;
    logic                  err;
    logic                  we;
    logic [23:0]           waddr;
    logic [7:0]            wdata;
  } mip_state_type;

  mip_state_type q;
  mip_state_type n;

  logic       sck_rise;
  logic       cs_rise;
  logic       cs_fall;
  logic [3:0] io_s;

  // Pins are read only after the second synchroniser stage
  assign io_s     = q.s2[3:0];
  assign sck_rise = q.s2[4] & ~q.prev[0];
  assign cs_rise  = q.s2[5] & ~q.prev[1];
  assign cs_fall  = ~q.s2[5] & q.prev[1];

  always_comb begin
    logic [7:0] opc;
    logic [7:0] nb;
    logic       last;
    opc  = {q.sh[6:0], io_s[0]};
    nb   = (q.mode == MIP_MODE_DUAL) ? {q.bsh[5:0], io_s[1:0]}
                                     : {q.bsh[3:0], io_s[3:0]};
    last = (q.mode == MIP_MODE_DUAL) ? (q.nib == MIP_DUAL_LAST)
                                     : (q.nib == MIP_QUAD_LAST);
    n      = q;
    n.s1   = {cs_n, sck, io_in};
    n.s2   = q.s1;
    n.prev = q.s2[5:4];
    n.we   = 1'b0;
    if (q.tmr != '0) begin
      n.tmr = q.tmr - 1'b1;
    end
    // The latch may not be set while an array cycle runs
    if (latch_set && !busy) begin
      n.latch = 1'b1;
    end
    case (q.st)
      MIP_ST_IDLE: begin
        if (cs_fall) begin
          n.st   = MIP_ST_CMD;
          n.bitc = '0;
          n.mode = MIP_MODE_NONE;
        end
      end
      MIP_ST_CMD: begin
        if (cs_rise) begin
          n.st = MIP_ST_IDLE;
          if (q.mode != MIP_MODE_NONE) begin
            n.latch = 1'b0;
          end
        end else if (sck_rise) begin
          n.sh   = {q.sh[29:0], io_s[0]};
          n.bitc = q.bitc + 5'h01;
          if (q.bitc == MIP_OPC_LAST) begin
            if (opc == MIP_OPC_DUAL) begin
              n.mode = MIP_MODE_DUAL;
            end else if (opc == MIP_OPC_QUAD) begin
              n.mode = MIP_MODE_QUAD;
            end else begin
              n.st = MIP_ST_IGNORE;
            end
            if (!q.latch) begin
              n.st = MIP_ST_IGNORE;
            end
          end
          if (q.bitc == MIP_HDR_LAST) begin
            n.addr = {q.sh[22:0], io_s[0]};
            n.ofs  = opc;
            n.st   = MIP_ST_DATA;
            n.nib  = '0;
            n.cnt  = '0;
            n.vld  = '0;
          end
        end
      end
      MIP_ST_DATA: begin
        if (cs_rise) begin
          // Aborts and the start of a program both drop the latch
          n.latch = 1'b0;
          if (q.cnt == '0 || q.nib != '0 || addr_protected) begin
            n.st = MIP_ST_IDLE;
          end else begin
            n.st   = MIP_ST_PROG;
            n.err  = 1'b0;
            n.idx  = '0;
            n.step = '0;
            n.tmr  = (q.cnt == 9'h001) ? TW'(BYTE_PROG_CYCLES - 1)
                                       : TW'(PAGE_PROG_CYCLES - 1);
          end
        end else if (sck_rise) begin
          n.bsh = nb;
          n.nib = q.nib + 2'h1;
          if (last) begin
            // Index wraps in the page, so newer bytes replace older ones
            n.nib          = '0;
            n.pbuf[q.ofs]  = nb;
            n.vld[q.ofs]   = 1'b1;
            n.ofs          = q.ofs + 8'h01;
            if (q.cnt != MIP_CNT_FULL) begin
              n.cnt = q.cnt + 9'h001;
            end
          end
        end
      end
      MIP_ST_PROG: begin
        case (q.step)
          2'h0: begin
            if (q.idx[8]) begin
              n.st = MIP_ST_WAIT;
            end else if (q.vld[q.idx[7:0]] &&
                         q.pbuf[q.idx[7:0]] != MIP_ERASED) begin
              // A byte of FFh would leave the erased cell as it is
              n.we    = 1'b1;
              n.waddr = {q.addr[23:8], q.idx[7:0]};
              n.wdata = q.pbuf[q.idx[7:0]];
              n.step  = 2'h1;
            end else begin
              n.idx = q.idx + 9'h001;
            end
          end
          2'h1: begin
            n.step = 2'h2;
          end
          default: begin
            if (arr_rdata != q.wdata) begin
              n.err = 1'b1;
            end
            n.idx  = q.idx + 9'h001;
            n.step = 2'h0;
          end
        endcase
      end
      MIP_ST_WAIT: begin
        if (q.tmr == '0) begin
          n.st = MIP_ST_IDLE;
        end
      end
      MIP_ST_IGNORE: begin
        if (cs_rise) begin
          n.st = MIP_ST_IDLE;
        end
      end
      default: begin
        n.st = MIP_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      q      <= '0;
      q.s1   <= MIP_PINS_IDLE;
      q.s2   <= MIP_PINS_IDLE;
      q.prev <= MIP_PREV_IDLE;
      q.st   <= MIP_ST_IDLE;
    end else begin
      q <= n;
    end
  end

  // Status readers see busy for the whole array cycle
  assign busy                     = (q.st == MIP_ST_PROG) ||
                                    (q.st == MIP_ST_WAIT);
  assign write_enable_latch       = q.latch;
  assign program_erase_error_flag = q.err;
  assign cmd_addr                 = q.addr;
  assign arr_we                   = q.we;
  assign arr_addr                 = q.waddr;
  assign arr_wdata                = q.wdata;

  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);

  a_opcode_needs_latch: assert property (
    q.st == MIP_ST_CMD && !cs_rise && sck_rise &&
    q.bitc == MIP_OPC_LAST && !q.latch |=> q.st == MIP_ST_IGNORE)
    else $error("command started without write enable latch");
  a_dual_byte_order: assert property (
    q.st == MIP_ST_DATA && !cs_rise && sck_rise &&
    q.mode == MIP_MODE_DUAL && q.nib == MIP_DUAL_LAST
    |=> q.pbuf[$past(q.ofs)] == {$past(q.bsh[5:0]), $past(io_s[1:0])})
    else $error("two-line byte assembled wrongly");
  a_quad_byte_order: assert property (
    q.st == MIP_ST_DATA && !cs_rise && sck_rise &&
    q.mode == MIP_MODE_QUAD && q.nib == MIP_QUAD_LAST
    |=> q.pbuf[$past(q.ofs)] == {$past(q.bsh[3:0]), $past(io_s)} &&
        q.ofs == $past(q.ofs) + 8'h01)
    else $error("four-line byte assembled or placed wrongly");
  a_count_limit: assert property (
    q.cnt <= MIP_CNT_FULL)
    else $error("byte count above one page");
  a_abort_clears: assert property (
    q.st == MIP_ST_DATA && cs_rise && (q.nib != '0 || q.cnt == '0)
    |=> q.st == MIP_ST_IDLE && !q.latch ##1 !busy)
    else $error("misaligned or empty frame not aborted");
  a_protect_idle: assert property (
    q.st == MIP_ST_DATA && cs_rise && addr_protected
    |=> !busy && !q.latch && !arr_we [*3])
    else $error("protected target was programmed");
  a_busy_no_latch: assert property (
    busy |-> !q.latch)
    else $error("write enable latch set during array cycle");
  a_write_in_page: assert property (
    arr_we |-> q.vld[arr_addr[7:0]] &&
               arr_addr[23:8] == q.addr[23:8] && arr_wdata != MIP_ERASED)
    else $error("write outside received bytes or page");
  a_verify_error: assert property (
    q.st == MIP_ST_PROG && q.step == 2'h2 && arr_rdata != q.wdata
    |=> program_erase_error_flag)
    else $error("failed byte did not raise the error flag");
  a_byte_time: assert property (
    q.st == MIP_ST_DATA && cs_rise && !addr_protected &&
    q.cnt == 9'h001 && q.nib == '0
    |=> q.tmr == TW'(BYTE_PROG_CYCLES - 1))
    else $error("single byte not timed with byte program time");
  a_write_spacing: assert property (
    arr_we |=> !arr_we ##1 !arr_we)
    else $error("array writes closer than three cycles");
  a_accept_starts: assert property (
    q.st == MIP_ST_DATA && cs_rise && !addr_protected &&
    q.cnt != '0 && q.nib == '0
    |=> busy && !q.latch && !program_erase_error_flag)
    else $error("accepted frame did not start a clean busy cycle");

endmodule

/* design/mip_pkg.sv */
package mip_pkg;

  // Command opcodes, shifted in on io_in[0] most significant bit first, and the erased byte value
  localparam logic [7:0] MIP_OPC_DUAL   = 8'ha2;
  localparam logic [7:0] MIP_OPC_QUAD   = 8'h32;
  localparam logic [7:0] MIP_ERASED     = 8'hff;

  localparam int         MIP_PAGE_BYTES = 256;
  localparam logic [8:0] MIP_CNT_FULL   = 9'h100;
  localparam logic [4:0] MIP_OPC_LAST   = 5'h07;
  localparam logic [4:0] MIP_HDR_LAST   = 5'h1f;
  localparam logic [1:0] MIP_DUAL_LAST  = 2'h3;
  localparam logic [1:0] MIP_QUAD_LAST  = 2'h1;

  localparam logic [1:0] MIP_MODE_NONE  = 2'h0;
  localparam logic [1:0] MIP_MODE_DUAL  = 2'h1;
  localparam logic [1:0] MIP_MODE_QUAD  = 2'h2;

  // Reset levels of the pin synchronisers: select released, clock low
  localparam logic [5:0] MIP_PINS_IDLE  = 6'h20;
  localparam logic [1:0] MIP_PREV_IDLE  = 2'h2;

  // Program times and their cycle counts at the system clock
  localparam int MIP_CLK_PERIOD_NS      = 10;
  localparam int MIP_PAGE_PROG_TIME_US  = 1000;
  localparam int MIP_BYTE_PROG_TIME_US  = 20;
  localparam int MIP_PAGE_PROG_CYC      =
    (MIP_PAGE_PROG_TIME_US * 1000) / MIP_CLK_PERIOD_NS;
  localparam int MIP_BYTE_PROG_CYC      =
    (MIP_BYTE_PROG_TIME_US * 1000) / MIP_CLK_PERIOD_NS;

  typedef enum logic [5:0] {
    MIP_ST_IDLE   = 6'b000001,
    MIP_ST_CMD    = 6'b000010,
    MIP_ST_DATA   = 6'b000100,
    MIP_ST_IGNORE = 6'b001000,
    MIP_ST_PROG   = 6'b010000,
    MIP_ST_WAIT   = 6'b100000
  } mip_st_type;

endpackage

/* test/mip_multi_io_program_tb.sv */
`timescale 1ns/1ns
module mip_multi_io_program_tb;
  import mip_pkg::*;
  localparam int PAGE_C = 1000;
  localparam int BYTE_C = 300;
  logic        clock = 1'b0;
  logic        arst_n = 1'b0;
  logic        sck, cs_n, latch_set = 1'b0, addr_protected = 1'b0;
  logic [3:0]  io_in;
  logic [23:0] cmd_addr, arr_addr;
  logic        busy, write_enable_latch, program_erase_error_flag, arr_we;
  logic [7:0]  arr_wdata, arr_rdata;
  logic [7:0]  mem [256];
  logic [7:0]  exp_pg [256];
  logic [15:0] wr_hi;
  logic        fault_en = 1'b0;
  int          errors = 0, cmp_count = 0, cycles = 0;
  int          wr_count = 0, busy_cyc = 0;

  always #5 clock = ~clock;
  // Verify reads see a corrupted cell while fault_en is set
  assign arr_rdata = mem[arr_addr[7:0]] ^ {8{fault_en}};

  mip_spi_host u_host (.sck(sck), .cs_n(cs_n), .io_in(io_in));

  mip_multi_io_program #(.PAGE_PROG_CYCLES(PAGE_C),
                         .BYTE_PROG_CYCLES(BYTE_C)) u_dut (
    .clock(clock), .arst_n(arst_n), .sck(sck), .cs_n(cs_n),
    .io_in(io_in), .latch_set(latch_set), .addr_protected(addr_protected),
    .cmd_addr(cmd_addr), .busy(busy),
    .write_enable_latch(write_enable_latch),
    .program_erase_error_flag(program_erase_error_flag),
    .arr_we(arr_we), .arr_addr(arr_addr), .arr_wdata(arr_wdata),
    .arr_rdata(arr_rdata));

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (busy === 1'b1) busy_cyc <= busy_cyc + 1;
    if (arr_we === 1'b1) begin
      mem[arr_addr[7:0]] <= arr_wdata;
      wr_hi              <= arr_addr[23:8];
      wr_count           <= wr_count + 1;
    end
    if (cycles == 60000) begin
      errors++;
      end_sim();
    end
  end

  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic prep(input logic lat);
    @(negedge clock);
    for (int i = 0; i < MIP_PAGE_BYTES; i++) begin
      mem[i]    = MIP_ERASED;
      exp_pg[i] = MIP_ERASED;
    end
    wr_count  = 0;
    busy_cyc  = 0;
    latch_set = lat;
    @(negedge clock);
    latch_set = 1'b0;
    repeat (4) @(negedge clock);
  endtask

  task automatic wait_idle(input logic eb);
    repeat (12) @(negedge clock);
    check("busy", busy, eb);
    check("latch", write_enable_latch, 1'b0);
    for (int i = 0; i < 2000 && busy !== 1'b0; i++) @(negedge clock);
    repeat (2) @(negedge clock);
  endtask

  task automatic run(input logic [7:0] opc, input logic [23:0] adr,
                     input int w, input int nb, input logic [7:0] base);
    prep(1'b1);
    for (int k = 0; k < nb; k++) exp_pg[8'(adr[7:0] + k)] = 8'(k * 7) ^ base;
    u_host.frame(opc, adr, w, 32, nb, 0, base);
    wait_idle(1'b1);
    for (int i = 0; i < 256; i++) check("page", mem[i], exp_pg[i]);
    check("addr hi", wr_hi, adr[23:8]);
    check("cmd addr", cmd_addr, adr);
  endtask

  task automatic t_dual();
    run(MIP_OPC_DUAL, 24'h0123fe, 2, 3, 8'h11);
    check("page time", busy_cyc >= PAGE_C && busy_cyc < PAGE_C + 30, 1);
    $display("test dual done");
  endtask

  task automatic t_quad();
    run(MIP_OPC_QUAD, 24'h004500, 4, 300, 8'h00);
    check("writes", wr_count, 255);
    $display("test quad done");
  endtask

  task automatic t_byte();
    fault_en = 1'b1;
    run(MIP_OPC_QUAD, 24'h000a10, 4, 1, 8'h3c);
    fault_en = 1'b0;
    check("byte time", busy_cyc >= BYTE_C && busy_cyc < BYTE_C + 30, 1);
    check("error flag", program_erase_error_flag, 1'b1);
    $display("test byte done");
  endtask

  task automatic refused(input int hdr, input int nb, input int xc,
                         input logic lat);
    prep(lat);
    u_host.frame(MIP_OPC_DUAL, 24'h000100, 2, hdr, nb, xc, 8'h22);
    wait_idle(1'b0);
    check("no write", wr_count, 0);
    check("no busy", busy_cyc, 0);
  endtask

  task automatic t_refuse();
    refused(32, 2, 0, 1'b0);
    refused(20, 0, 0, 1'b1);
    refused(32, 0, 0, 1'b1);
    refused(32, 1, 1, 1'b1);
    addr_protected = 1'b1;
    refused(32, 2, 0, 1'b1);
    addr_protected = 1'b0;
    $display("test refuse done");
  endtask

  // Unknown opcode: rest of frame ignored, latch left set
  task automatic t_other();
    prep(1'b1);
    u_host.frame(8'h5a, 24'h000200, 2, 32, 2, 0, 8'h44);
    repeat (12) @(negedge clock);
    check("kept latch", write_enable_latch, 1'b1);
    check("other write", wr_count, 0);
    check("other busy", busy_cyc, 0);
    $display("test other done");
  endtask

  // Reset while idle with latch and error set clears both, then a program still works
  task automatic t_reset();
    @(negedge clock);
    arst_n = 1'b0;
    @(negedge clock);
    check("rst busy", busy, 1'b0);
    check("rst latch", write_enable_latch, 1'b0);
    check("rst error", program_erase_error_flag, 1'b0);
    check("rst we", arr_we, 1'b0);
    check("rst addr", cmd_addr, 24'h000000);
    repeat (3) @(negedge clock);
    arst_n = 1'b1;
    repeat (4) @(negedge clock);
    run(MIP_OPC_DUAL, 24'h0031f0, 2, 2, 8'h5a);
    $display("test reset done");
  endtask

  initial begin
    repeat (4) @(posedge clock);
    @(negedge clock);
    arst_n = 1'b1;
    repeat (4) @(negedge clock);
    t_dual();
    t_quad();
    t_byte();
    t_refuse();
    t_other();
    t_reset();
    end_sim();
  end
endmodule

/* test/mip_spi_host.sv */
`timescale 1ns/1ns
module mip_spi_host (
  // Serial bus
  output logic       sck,
  output logic       cs_n,
  output logic [3:0] io_in
);
  initial begin
    sck   = 1'b0;
    cs_n  = 1'b1;
    io_in = 4'h0;
  end

  // 125 ns serial clock, only inside frames
  task automatic bit_clk(input logic [3:0] v);
    io_in = v;
    #62 sck = 1'b1;
    #63 sck = 1'b0;
  endtask

  // Header bits on io0, nb bytes at w bits a clock, then xc stray clocks
  task automatic frame(input logic [7:0] opc, input logic [23:0] adr,
                       input int w, input int hdr, input int nb,
                       input int xc, input logic [7:0] base);
    logic [31:0] h;
    logic [7:0]  b;
    h = {opc, adr};
    #1 cs_n = 1'b0;
    for (int i = 0; i < hdr; i++) begin
      bit_clk({~io_in[3:1], h[31-i]});
    end
    for (int k = 0; k < nb; k++) begin
      b = 8'(k * 7) ^ base;
      for (int c = 0; c < 8 / w; c++) begin
        bit_clk(w == 2 ? {~io_in[3:2], b[7:6]} : b[7:4]);
        b = b << w;
      end
    end
    for (int i = 0; i < xc; i++) begin
      bit_clk(~io_in);
    end
    #62 cs_n = 1'b1;
    // Undriven lines must not keep the last value
    io_in = ~io_in;
  endtask
endmodule
